// >>> hw/tdm_pkg.sv
package tdm_pkg;
   localparam int          SLOT_BITS   = 32;
   localparam int          TDM_SLOTS   = 8;
   localparam int          I2S_SLOTS   = 2;
   localparam int          SAMPLE_W    = 24;
   localparam int          MIN_WL      = 16;
   localparam int          VOL_W       = 8;
   localparam int          CH_W        = 3;
   localparam int          BIT_CNT_W   = 8;
   localparam logic [7:0]  TDM_LAST    = 8'h00_FF;
   localparam logic [7:0]  I2S_LAST    = 8'h00_3F;
   localparam logic [4:0]  MSB_POS     = 5'h00;
   localparam logic [4:0]  LSB_POS     = 5'h17;
   localparam logic [4:0]  WL_MIN      = 5'h10;
   localparam logic [4:0]  WL_MAX      = 5'h18;
   localparam logic [7:0]  VOL_UNITY   = 8'h0080;
   localparam logic [23:0] FULL_SCALE  = 24'hFF_FFFF;
   localparam logic [23:0] SAMPLE_RST  = 24'h00_0000;

   typedef enum logic {
      TDM_MODE_TDM,
      TDM_MODE_I2S
   } tdm_mode_t;

   // surround order of slots after the frame start
   typedef enum logic [CH_W-1:0] {
      TDM_CH_FRONT_LEFT,
      TDM_CH_FRONT_RIGHT,
      TDM_CH_CENTER,
      TDM_CH_LOW_FREQUENCY,
      TDM_CH_BACK_LEFT,
      TDM_CH_BACK_RIGHT,
      TDM_CH_SIDE_LEFT,
      TDM_CH_SIDE_RIGHT
   } tdm_chan_t;
endpackage : tdm_pkg

// >>> hw/tdm_playback_port.sv
`timescale 1ns/1ps
module tdm_playback_port
   import tdm_pkg::*;
#(
   parameter int DEPTH = 2                       // buffer entries
)(
   input  wire logic                  mclk_in,        // 100 MHz clock
   input  wire logic                  rst_in,         // async reset, high
   input  wire logic                  bit_clock_in,   // host bit clock pin
   input  wire logic                  playback_frame_sync_in, // frame sync
   input  wire logic                  serial_data_in, // host data pin
   input  wire tdm_pkg::tdm_mode_t    mode_in,        // tdm or classic i2s
   input  wire logic [4:0]            word_len_in,    // 16..24 bits
   input  wire logic [tdm_pkg::TDM_SLOTS-1:0][tdm_pkg::VOL_W-1:0]
                                      vol_in,         // gain, 0x80 unity
   output logic                       samp_valid_out, // sample available
   input  wire logic                  samp_ready_in,  // converter takes it
   output logic [tdm_pkg::SAMPLE_W-1:0] samp_data_out, // scaled sample
   output tdm_pkg::tdm_chan_t         samp_chan_out,  // channel of sample
   output logic                       overflow_out    // word dropped, pulse
);
   import tdm_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int EW = SAMPLE_W + CH_W;

   // pointers wrap by overflow, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
      $error("tdm_playback_port: DEPTH must be a power of two >= 2");
   end

   typedef struct packed {
      logic                    sclk_s1;
      logic                    sclk_s2;
      logic                    sclk_d;
      logic                    fs_s1;
      logic                    fs_s2;
      logic                    sd_s1;
      logic                    sd_s2;
      logic                    fs_prev;
      logic                    armed;
      logic                    active;
      logic [BIT_CNT_W-1:0]    bit_cnt;
      logic [SAMPLE_W-1:0]     shift;
      logic [DEPTH-1:0][EW-1:0] mem;
      logic [AW-1:0]           wr_ptr;
      logic [AW-1:0]           rd_ptr;
      logic [AW:0]             count;
      logic                    overflow;
      // assertion helpers: first slot bit, slots pushed this frame
      logic                    msb_first;
      logic [CH_W-1:0]         slot_seen;
   } tdm_state_t;

   tdm_state_t st_r;
   tdm_state_t st_nxt;

   logic                    rise;
   logic                    start;
   logic                    cap;
   logic [BIT_CNT_W-1:0]    idx;
   logic [BIT_CNT_W-1:0]    last_bit;
   logic [4:0]              wl_eff;
   logic [SAMPLE_W-1:0]     mask;
   logic [SAMPLE_W-1:0]     raw;
   logic                    push;
   logic                    pop;
   logic [CH_W-1:0]         chan;
   logic [VOL_W-1:0]        gain;
   logic signed [32:0]      prod;
   logic [SAMPLE_W-1:0]     scaled;

   always_comb begin
      st_nxt = st_r;
      // two-stage synchronisers on the host pins
      st_nxt.sclk_s1 = bit_clock_in;
      st_nxt.sclk_s2 = st_r.sclk_s1;
      st_nxt.sclk_d  = st_r.sclk_s2;
      st_nxt.fs_s1   = playback_frame_sync_in;
      st_nxt.fs_s2   = st_r.fs_s1;
      st_nxt.sd_s1   = serial_data_in;
      st_nxt.sd_s2   = st_r.sd_s1;

      rise = st_r.sclk_s2 & ~st_r.sclk_d;
      // tdm frames start on sync rise, i2s left word on sync fall
      start = (mode_in == TDM_MODE_TDM)
            ? (st_r.fs_s2 & ~st_r.fs_prev)
            : (~st_r.fs_s2 & st_r.fs_prev);
      last_bit = (mode_in == TDM_MODE_TDM) ? TDM_LAST
                                           : I2S_LAST;
      cap = rise & ~start & (st_r.armed | st_r.active);
      idx = st_r.armed ? '0 : st_r.bit_cnt + 8'h01;

      wl_eff = (word_len_in < WL_MIN) ? WL_MIN
             : (word_len_in > WL_MAX) ? WL_MAX : word_len_in;
      mask = ~(FULL_SCALE >> wl_eff);
      raw  = {st_r.shift[SAMPLE_W-2:0], st_r.sd_s2} & mask;
      chan = idx[BIT_CNT_W-1:5];
      push = cap & (idx[4:0] == LSB_POS);

      // gain above unity would overflow the 24-bit output, so clamp
      gain   = vol_in[chan];
      if (gain > VOL_UNITY)
         gain = VOL_UNITY;
      prod   = $signed(raw) * $signed({1'b0, gain});
      scaled = prod[SAMPLE_W+6:7];

      // sync level is only taken at bit clock rises, like the data
      if (rise) begin
         st_nxt.fs_prev = st_r.fs_s2;
      end
      if (rise && start) begin
         st_nxt.armed  = 1'b1;
         st_nxt.active = 1'b0;
      end else if (cap) begin
         st_nxt.armed   = 1'b0;
         st_nxt.bit_cnt = idx;
         st_nxt.active  = (idx != last_bit);
         // msb first; clear at slot start
         if (idx[4:0] == MSB_POS) begin
            st_nxt.shift     = {{(SAMPLE_W-1){1'b0}}, st_r.sd_s2};
            st_nxt.msb_first = st_r.sd_s2;
         end else if (idx[4:0] <= LSB_POS) begin
            st_nxt.shift = {st_r.shift[SAMPLE_W-2:0], st_r.sd_s2};
         end
      end
      // slots delivered since the last frame start, for the order check
      if (rise && start)
         st_nxt.slot_seen = '0;
      else if (push)
         st_nxt.slot_seen = st_r.slot_seen + 1'b1;

      pop = samp_ready_in & (st_r.count != '0);
      // a full buffer drops the new word and keeps the older ones
      st_nxt.overflow = 1'b0;
      if (push && st_r.count == (AW+1)'(DEPTH) && !pop) begin
         st_nxt.overflow = 1'b1;
      end else if (push) begin
         st_nxt.mem[st_r.wr_ptr] = {chan, scaled};
         st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
      end
      if (pop)
         st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
      if ((push && !st_nxt.overflow) && !pop)
         st_nxt.count = st_r.count + 1'b1;
      else if (pop && !(push && !st_nxt.overflow))
         st_nxt.count = st_r.count - 1'b1;
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // output side reads the oldest entry straight from the flops
   assign samp_valid_out = (st_r.count != '0);
   assign samp_data_out  = st_r.mem[st_r.rd_ptr][SAMPLE_W-1:0];
   assign samp_chan_out  = tdm_chan_t'(st_r.mem[st_r.rd_ptr][EW-1:SAMPLE_W]);
   assign overflow_out   = st_r.overflow;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   AST_BIT_ON_RISE: assert property (
      $changed(st_r.bit_cnt) |-> $past(rise))
      else $error("bit counter moved without bit clock rise");

   AST_FIRST_BIT: assert property (
      $rose(st_r.active) |-> st_r.bit_cnt == '0 && $past(st_r.armed)
                             && $past(rise))
      else $error("first bit not on second rise after sync");

   AST_MSB_FIRST: assert property (
      push && (idx[4:0] != MSB_POS) |-> raw[SAMPLE_W-1] == st_r.msb_first)
      else $error("sample msb is not the first slot bit");

   AST_TDM_FRAME: assert property (
      $fell(st_r.active) && mode_in == TDM_MODE_TDM && !$past(start)
      |-> st_r.bit_cnt == TDM_LAST)
      else $error("tdm frame did not span 256 bits");

   AST_I2S_FRAME: assert property (
      push && mode_in == TDM_MODE_I2S |-> chan < CH_W'(I2S_SLOTS))
      else $error("i2s frame produced more than two channels");

   AST_WORD_LEN: assert property (
      push |-> (raw << wl_eff) == '0)
      else $error("bits below word length not zero");

   AST_VOL_MUTE: assert property (
      push && vol_in[chan] == '0 && st_r.count == '0
      |=> samp_valid_out && samp_data_out == '0)
      else $error("muted channel passed nonzero data");

   AST_VOL_UNITY: assert property (
      push && vol_in[chan] >= VOL_UNITY && st_r.count == '0
      |=> samp_valid_out && samp_data_out == $past(raw)
          && samp_chan_out == tdm_chan_t'($past(chan)))
      else $error("unity gain changed the sample or slot order");

   AST_SLOT_ORDER: assert property (
      push |-> chan == st_r.slot_seen && idx[4:0] == LSB_POS)
      else $error("sample emitted outside its slot");

   AST_BUF_BOUND: assert property (
      st_r.count <= (AW+1)'(DEPTH))
      else $error("buffer count beyond depth");
endmodule : tdm_playback_port

// >>> sim/tdm_host_model.sv
`timescale 1ns/1ps
module tdm_host_model;
   logic bit_clock_out  = 1'b0;          // stands low outside frames
   logic frame_sync_out = 1'b0;          // frame start marker
   logic data_out       = 1'b0;          // serial data line

   // one frame, 160 ns bit clock; data changes only after a fall
   task automatic send(input logic i2s, input int nbits,
                       input logic [7:0][31:0] s);
      int b;
      #3;
      for (int r = -1; r <= nbits; r++) begin
         b = r - 1;
         frame_sync_out = i2s ? (r < 0 || r >= 32) : (r == 0);
         // whole four-byte word goes out; the low byte fills bits 24..31
         if (b >= 0)
            data_out = s[b / 32][31 - b % 32];
         #80 bit_clock_out = 1'b1;
         #80 bit_clock_out = 1'b0;
      end
      data_out = ~data_out;              // data line inverted after the frame, still driven
   endtask : send
endmodule : tdm_host_model

// >>> sim/tdm_playback_port_test.sv
`timescale 1ns/1ps
module tdm_playback_port_test;
   import tdm_pkg::*;
   logic                             mclk_in       = 1'b0;
   logic                             rst_in        = 1'b1;
   logic                             samp_ready_in = 1'b0;
   tdm_mode_t                        mode_in       = TDM_MODE_TDM;
   logic [4:0]                       word_len_in   = 5'h18;
   logic [TDM_SLOTS-1:0][VOL_W-1:0]  vol_in        = {8{8'h80}};
   logic                             samp_valid_out;
   logic [SAMPLE_W-1:0]              samp_data_out;
   tdm_chan_t                        samp_chan_out;
   logic                             overflow_out;
   logic [7:0][31:0]                 smp;    // four-byte host words
   int n_mismatch = 0, num_checks = 0, n_ovf = 0, cycles = 0;

   tdm_host_model tdm_host_model_i ();
   tdm_playback_port tdm_playback_port_i (
      .mclk_in(mclk_in), .rst_in(rst_in),
      .bit_clock_in(tdm_host_model_i.bit_clock_out),
      .playback_frame_sync_in(tdm_host_model_i.frame_sync_out),
      .serial_data_in(tdm_host_model_i.data_out),
      .mode_in(mode_in), .word_len_in(word_len_in), .vol_in(vol_in),
      .samp_valid_out(samp_valid_out), .samp_ready_in(samp_ready_in),
      .samp_data_out(samp_data_out), .samp_chan_out(samp_chan_out),
      .overflow_out(overflow_out));

   initial begin
      forever #5 mclk_in = ~mclk_in;
   end
   always @(negedge mclk_in) begin
      cycles++;
      if (overflow_out === 1'b1) n_ovf++;
      if (cycles == 40000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // expected output from word length clamp, gain clamp and Q1.7 scaling
   function automatic logic [23:0] calc(input int k);
      logic signed [33:0] p;
      int w, g;
      w = word_len_in < 16 ? 16 : (word_len_in > 24 ? 24 : int'(word_len_in));
      g = vol_in[k] > 8'h80 ? 128 : int'(vol_in[k]);
      p = $signed(smp[k][31:8] & (24'hFF_FFFF << (24 - w))) * g;
      return 24'(p >>> 7);
   endfunction : calc

   task automatic recv(input int n);
      int t;
      for (int k = 0; k < n; k++) begin
         t = 0;
         while (samp_valid_out !== 1'b1 && t < 9000) begin
            @(negedge mclk_in);
            t++;
         end
         check(samp_valid_out, 1'b1);
         check(samp_chan_out, k);
         check(samp_data_out, calc(k));
         samp_ready_in = 1'b1;
         @(negedge mclk_in);
         samp_ready_in = 1'b0;
         // let an edge pass so ready is never lowered and raised at once
         @(negedge mclk_in);
      end
   endtask : recv

   task automatic t_vol;
      @(negedge mclk_in);
      vol_in = {8'h00, 8'hFF, 8'h81, 8'h80, 8'h7F, 8'h40, 8'h20, 8'h01};
      fork
         tdm_host_model_i.send(1'b0, 256, smp);
         recv(8);
      join
   endtask : t_vol

   task automatic t_wl;
      @(negedge mclk_in);
      vol_in = {8{8'h80}};
      word_len_in = 5'h08;                // clamped up to 16
      fork
         tdm_host_model_i.send(1'b0, 256, smp);
         recv(8);
      join
      @(negedge mclk_in);
      word_len_in = 5'h18;
   endtask : t_wl

   task automatic t_i2s;
      @(negedge mclk_in);
      mode_in = TDM_MODE_I2S;
      fork
         tdm_host_model_i.send(1'b1, 64, smp);
         recv(2);
      join
      @(negedge mclk_in);
      mode_in = TDM_MODE_TDM;
   endtask : t_i2s

   task automatic t_ovf;
      @(negedge mclk_in);
      n_ovf = 0;
      tdm_host_model_i.send(1'b0, 256, smp);
      @(negedge mclk_in);
      check(n_ovf, 6);
      recv(2);
      @(negedge mclk_in);
      check(samp_valid_out, 1'b0);
   endtask : t_ovf

   task automatic end_of_test;
      if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   initial begin
      for (int k = 0; k < 8; k++) smp[k] = 32'h9A5C_3EA5 + 32'h1020_11C3 * k;
      repeat (3) @(posedge mclk_in);
      @(negedge mclk_in);
      check(samp_valid_out, 1'b0);
      check(overflow_out, 1'b0);
      rst_in = 1'b0;
      repeat (4) @(negedge mclk_in);
      t_vol();
      t_wl();
      t_i2s();
      t_ovf();
      end_of_test();
   end
endmodule : tdm_playback_port_test
